//--- bmrf_core.sv
// banked register file with operating mode and access checks
`timescale 1ns/100ps
`default_nettype none
module bmrf_core
    import bmrf_pkg::*;
#(
    parameter int EXT_W = EXT_AW             // address bits driven out
)(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,                   // freezes all state when low
    input wire logic wide_program_space_bit_i,
    input wire logic wide_data_space_bit_i,
    input wire logic [3:0] rd_a_idx_i,       // read port a register
    input wire logic [3:0] rd_b_idx_i,       // read port b register
    input wire logic wr_en_i,                // register write
    input wire logic [3:0] wr_idx_i,
    input wire logic wr_byte_i,              // byte load, zero extended
    input wire logic [DATA_W-1:0] wr_data_i,
    input wire logic mode_req_i,             // software mode change
    input wire logic [4:0] mode_val_i,       // requested mode code
    input wire logic irq_i,                  // interrupt request level
    input wire logic fiq_i,                  // fast interrupt level
    input wire logic dabort_i,               // data abort event
    input wire logic pabort_i,               // prefetch abort event
    input wire logic undef_i,                // unknown instruction event
    input wire logic [DATA_W-1:0] exc_link_i, // return address on entry
    input wire logic acc_valid_i,            // memory access request
    input wire logic acc_fetch_i,            // instruction fetch
    input wire logic acc_word_i,             // word (1) or byte (0)
    input wire logic [ADDR_W-1:0] acc_addr_i,
    output logic [DATA_W-1:0] rd_a_o,
    output logic [DATA_W-1:0] rd_b_o,
    output logic [DATA_W-1:0] cpsr_o,        // current status word
    output logic [DATA_W-1:0] spsr_o,        // saved status, 0 in user
    output logic priv_o,                     // privileged mode
    output logic [EXT_W-1:0] ext_addr_o,     // pin address
    output logic ext_req_o,                  // access goes out
    output logic ext_byte_o,                 // byte lane access
    output logic align_err_o,                // misaligned word
    output logic addr_exc_o                  // narrow space overflow
);
    // physical storage
    logic [DATA_W-1:0] regs_ff [GPR_N];
    logic [DATA_W-1:0] nxt_regs [GPR_N];
    logic [DATA_W-1:0] spsr_ff [SPSR_N];     // saved status words
    logic [DATA_W-1:0] nxt_spsr [SPSR_N];
    bmrf_mode_t mode_ff, nxt_mode;
    logic [1:0] mask_ff, nxt_mask;           // {i, f} disables
    // registered outputs
    logic [DATA_W-1:0] nxt_rd_a, nxt_rd_b, nxt_cpsr, nxt_spsr_o;
    logic [EXT_W-1:0] nxt_ext_addr;
    logic nxt_priv, nxt_req, nxt_byte, nxt_align, nxt_aexc;
    // combinational helpers
    logic narrow;                            // narrow program space
    logic take;                              // exception accepted
    bmrf_mode_t tgt;                         // exception target mode
    logic [4:0] rd_a_phys, rd_b_phys, wr_phys, lr_phys;
    logic [DATA_W-1:0] cur_psr;
    logic is_word, align_bad, aexc, hi_exc;

    assign narrow = !wide_program_space_bit_i;

    // visible register selection, one map per port
    bmrf_bank_map u_map_a (
        .mode_i(mode_ff),
        .idx_i(rd_a_idx_i),
        .phys_o(rd_a_phys)
    );
    bmrf_bank_map u_map_b (
        .mode_i(mode_ff),
        .idx_i(rd_b_idx_i),
        .phys_o(rd_b_phys)
    );
    bmrf_bank_map u_map_w (
        .mode_i(mode_ff),
        .idx_i(wr_idx_i),
        .phys_o(wr_phys)
    );
    bmrf_bank_map u_map_l (                  // link of target mode
        .mode_i(tgt),
        .idx_i(IDX_LR),
        .phys_o(lr_phys)
    );

    // encodes a mode for the status word
    function automatic logic [4:0] mcode(bmrf_mode_t m, logic nar);
        logic [4:0] c;
        case (m)
            MD_FIQ: c = nar ? MC26_FIQ : MC_FIQ;
            MD_IRQ: c = nar ? MC26_IRQ : MC_IRQ;
            MD_SVC: c = nar ? MC26_SVC : MC_SVC;
            MD_ABT: c = MC_ABT;
            MD_UND: c = MC_UND;
            default: c = nar ? MC26_USR : MC_USR;
        endcase
        return c;
    endfunction

    // saved status slot of a privileged mode
    function automatic logic [2:0] slot(bmrf_mode_t m);
        logic [2:0] s;
        case (m)
            MD_FIQ: s = SL_FIQ;
            MD_IRQ: s = SL_IRQ;
            MD_ABT: s = SL_ABT;
            MD_UND: s = SL_UND;
            default: s = SL_SVC;
        endcase
        return s;
    endfunction

    // access checks on the memory request
    always_comb begin
        is_word = acc_word_i | acc_fetch_i;
        align_bad = acc_valid_i && is_word
            && (acc_addr_i[1:0] != 2'h0);
        // wide program with narrow data is not supported and acts
        // as narrow data here
        aexc = acc_valid_i && (|acc_addr_i[ADDR_W-1:NARROW_AW])
            && (acc_fetch_i ? narrow
                : !wide_data_space_bit_i);
        cur_psr = WORD_RST;
        cur_psr[PSR_I] = mask_ff[1];
        cur_psr[PSR_F] = mask_ff[0];
        cur_psr[4:0] = mcode(mode_ff, narrow);
    end

    // exception arbitration, highest priority first
    always_comb begin
        take = 1'b1;
        tgt = MD_SVC;
        hi_exc = dabort_i || aexc || (fiq_i && !mask_ff[0])
            || (irq_i && !mask_ff[1]) || pabort_i;
        if (aexc) begin
            tgt = MD_SVC;
        end else if (dabort_i) begin
            tgt = narrow ? MD_SVC : MD_ABT;
        end else if (fiq_i && !mask_ff[0]) begin
            tgt = MD_FIQ;
        end else if (irq_i && !mask_ff[1]) begin
            tgt = MD_IRQ;
        end else if (pabort_i) begin
            tgt = narrow ? MD_SVC : MD_ABT;
        end else if (undef_i) begin
            tgt = narrow ? MD_SVC : MD_UND;
        end else begin
            take = 1'b0;
        end
    end

    // mode and status next state
    always_comb begin
        nxt_mode = mode_ff;
        nxt_mask = mask_ff;
        nxt_spsr = spsr_ff;
        if (take) begin
            nxt_spsr[slot(tgt)] = cur_psr;
            nxt_mode = tgt;
            nxt_mask[1] = 1'b1;
            nxt_mask[0] = mask_ff[0] | (tgt == MD_FIQ);
        end else if (mode_req_i && mode_ff != MD_USR) begin
            // illegal codes for the configuration are ignored
            case (mode_val_i)
                MC26_USR: if (narrow) nxt_mode = MD_USR;
                MC26_FIQ: if (narrow) nxt_mode = MD_FIQ;
                MC26_IRQ: if (narrow) nxt_mode = MD_IRQ;
                MC26_SVC: if (narrow) nxt_mode = MD_SVC;
                MC_USR: if (!narrow) nxt_mode = MD_USR;
                MC_FIQ: if (!narrow) nxt_mode = MD_FIQ;
                MC_IRQ: if (!narrow) nxt_mode = MD_IRQ;
                MC_SVC: if (!narrow) nxt_mode = MD_SVC;
                MC_ABT: if (!narrow) nxt_mode = MD_ABT;
                MC_UND: if (!narrow) nxt_mode = MD_UND;
                default: nxt_mode = mode_ff;
            endcase
        end else if (narrow && (mode_ff == MD_ABT
            || mode_ff == MD_UND)) begin
            nxt_mode = MD_SVC;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            mode_ff <= MD_SVC;
            mask_ff <= MASK_RST;
            for (int i = 0; i < SPSR_N; i++) begin
                spsr_ff[i] <= WORD_RST;
            end
        end else if (ce_i) begin
            mode_ff <= nxt_mode;
            mask_ff <= nxt_mask;
            spsr_ff <= nxt_spsr;
        end
    end

    // register writes; exception link write wins
    always_comb begin
        nxt_regs = regs_ff;
        if (wr_en_i) begin
            nxt_regs[wr_phys] = wr_byte_i
                ? {24'h00_0000, wr_data_i[7:0]}
                : wr_data_i;
        end
        if (take) begin
            nxt_regs[lr_phys] = exc_link_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            for (int i = 0; i < GPR_N; i++) begin
                regs_ff[i] <= WORD_RST;
            end
        end else if (ce_i) begin
            regs_ff <= nxt_regs;
        end
    end

    // output values
    always_comb begin
        nxt_rd_a = regs_ff[rd_a_phys];
        nxt_rd_b = regs_ff[rd_b_phys];
        nxt_cpsr = cur_psr;
        nxt_spsr_o = (mode_ff == MD_USR) ? WORD_RST
            : spsr_ff[slot(mode_ff)];
        nxt_priv = (mode_ff != MD_USR);
        nxt_ext_addr = acc_addr_i[EXT_W-1:0];
        nxt_req = acc_valid_i && !align_bad && !aexc;
        nxt_byte = acc_valid_i && !is_word;
        nxt_align = align_bad;
        nxt_aexc = aexc;
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            rd_a_o <= WORD_RST;
            rd_b_o <= WORD_RST;
            cpsr_o <= WORD_RST;
            spsr_o <= WORD_RST;
            priv_o <= 1'b0;
            ext_addr_o <= '0;
            ext_req_o <= 1'b0;
            ext_byte_o <= 1'b0;
            align_err_o <= 1'b0;
            addr_exc_o <= 1'b0;
        end else if (ce_i) begin
            rd_a_o <= nxt_rd_a;
            rd_b_o <= nxt_rd_b;
            cpsr_o <= nxt_cpsr;
            spsr_o <= nxt_spsr_o;
            priv_o <= nxt_priv;
            ext_addr_o <= nxt_ext_addr;
            ext_req_o <= nxt_req;
            ext_byte_o <= nxt_byte;
            align_err_o <= nxt_align;
            addr_exc_o <= nxt_aexc;
        end
    end

    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    sequence s_taken;
        ce_i && take;
    endsequence
    sequence s_next_live;
        ce_i;
    endsequence

    chk_narrow_four: assert property (
        ce_i && narrow |=> mode_ff inside {MD_USR, MD_FIQ,
            MD_IRQ, MD_SVC})
        else $error("narrow config left the four narrow modes");
    chk_pin_addr: assert property (
        ce_i && acc_valid_i |=>
            ext_addr_o == $past(acc_addr_i[EXT_W-1:0]))
        else $error("pin address does not follow request");
    chk_align_word: assert property (
        ce_i && acc_valid_i && (acc_fetch_i || acc_word_i)
            && (acc_addr_i[1:0] != 2'h0) |=> align_err_o && !ext_req_o)
        else $error("misaligned word went out");
    chk_byte_zext: assert property (
        ce_i && wr_en_i && wr_byte_i && !take
            |=> regs_ff[$past(wr_phys)][31:8] == 24'h00_0000)
        else $error("byte load not zero extended");
    chk_abort_entry: assert property (
        ce_i && dabort_i && !aexc && !narrow |=> mode_ff == MD_ABT)
        else $error("data abort did not enter abort mode");
    chk_undef_entry: assert property (
        ce_i && undef_i && !hi_exc && !narrow |=> mode_ff == MD_UND)
        else $error("undefined instruction not taken");
    chk_user_locked: assert property (
        ce_i && mode_ff == MD_USR && !take |=> mode_ff == MD_USR)
        else $error("user mode changed mode without exception");
    chk_spsr_save: assert property (
        s_taken ##1 s_next_live |=> spsr_o == $past(cur_psr, 2))
        else $error("saved status differs from entry status");
    chk_shared_low: assert property (
        wr_idx_i < IDX_SHARED |-> wr_phys == {1'b0, wr_idx_i})
        else $error("low register was banked");
    chk_bank_swap: assert property (
        mode_ff != MD_USR && rd_a_idx_i == IDX_SP
            |-> rd_a_phys != {1'b0, IDX_SP})
        else $error("privileged mode reads user stack copy");
    chk_wide_data: assert property (
        ce_i && acc_valid_i && !acc_fetch_i && wide_data_space_bit_i
            |=> !addr_exc_o)
        else $error("address exception with wide data space");
endmodule
`default_nettype wire

//--- bmrf_pkg.sv
// constants and types shared by the banked register mode file
package bmrf_pkg;
    localparam int DATA_W = 32;              // internal data path width
    localparam int ADDR_W = 32;              // internal address width
    localparam int EXT_AW = 29;              // address bits reaching pins
    localparam int NARROW_AW = 26;           // narrow program/data space
    localparam int GPR_N = 31;               // physical general registers
    localparam int SPSR_N = 5;               // saved status registers
    localparam int PIDX_W = 5;               // physical index width
    // physical base of each banked group
    localparam logic [4:0] PB_FIQ = 5'h10;   // fiq r8..r14
    localparam logic [4:0] PB_SVC = 5'h17;   // svc r13..r14
    localparam logic [4:0] PB_ABT = 5'h19;   // abt r13..r14
    localparam logic [4:0] PB_IRQ = 5'h1B;   // irq r13..r14
    localparam logic [4:0] PB_UND = 5'h1D;   // und r13..r14
    // architectural register numbers
    localparam logic [3:0] IDX_SHARED = 4'h8; // first possibly banked
    localparam logic [3:0] IDX_SP = 4'hD;
    localparam logic [3:0] IDX_LR = 4'hE;
    localparam logic [3:0] IDX_PC = 4'hF;
    // wide mode codes
    localparam logic [4:0] MC_USR = 5'h10;
    localparam logic [4:0] MC_FIQ = 5'h11;
    localparam logic [4:0] MC_IRQ = 5'h12;
    localparam logic [4:0] MC_SVC = 5'h13;
    localparam logic [4:0] MC_ABT = 5'h17;
    localparam logic [4:0] MC_UND = 5'h1B;
    // narrow mode codes
    localparam logic [4:0] MC26_USR = 5'h00;
    localparam logic [4:0] MC26_FIQ = 5'h01;
    localparam logic [4:0] MC26_IRQ = 5'h02;
    localparam logic [4:0] MC26_SVC = 5'h03;
    // status word layout
    localparam int PSR_I = 7;                // interrupt disable
    localparam int PSR_F = 6;                // fast interrupt disable
    localparam logic [1:0] MASK_RST = 2'h3;  // both disabled at reset
    // saved status slot per privileged mode
    localparam logic [2:0] SL_FIQ = 3'h0;
    localparam logic [2:0] SL_SVC = 3'h1;
    localparam logic [2:0] SL_ABT = 3'h2;
    localparam logic [2:0] SL_IRQ = 3'h3;
    localparam logic [2:0] SL_UND = 3'h4;
    localparam logic [31:0] WORD_RST = 32'h0000_0000;
    // operating modes, one-hot
    typedef enum logic [5:0] {
        MD_USR = 6'h01,
        MD_FIQ = 6'h02,
        MD_IRQ = 6'h04,
        MD_SVC = 6'h08,
        MD_ABT = 6'h10,
        MD_UND = 6'h20
    } bmrf_mode_t;
endpackage

//--- bmrf_bank_map.sv
// maps an architectural register number to its physical slot
`timescale 1ns/100ps
`default_nettype none
module bmrf_bank_map
    import bmrf_pkg::*;
(
    input wire bmrf_mode_t mode_i,           // current or target mode
    input wire logic [3:0] idx_i,            // register number 0..15
    output logic [PIDX_W-1:0] phys_o         // physical slot 0..30
);
    // user copy unless the mode owns a banked copy
    always_comb begin
        phys_o = {1'b0, idx_i};
        if (idx_i >= IDX_SHARED && idx_i < IDX_PC) begin
            if (mode_i == MD_FIQ) begin
                phys_o = PB_FIQ + 5'(idx_i - IDX_SHARED);
            end else if (idx_i >= IDX_SP) begin
                case (mode_i)
                    MD_SVC: phys_o = PB_SVC + 5'(idx_i - IDX_SP);
                    MD_ABT: phys_o = PB_ABT + 5'(idx_i - IDX_SP);
                    MD_IRQ: phys_o = PB_IRQ + 5'(idx_i - IDX_SP);
                    MD_UND: phys_o = PB_UND + 5'(idx_i - IDX_SP);
                    default: phys_o = {1'b0, idx_i};
                endcase
            end
        end
    end
endmodule
`default_nettype wire

//--- tb_bmrf_core.sv
// self-checking testbench for the banked register mode file core
`timescale 1ns/100ps
`default_nettype none
module tb_bmrf_core;
    import bmrf_pkg::*;
    // everything the bench drives, applied together at one edge
    typedef struct packed {
        logic rstn, ce, wp, wd;
        logic [3:0] ra, rb, widx;
        logic we, wbyte, mreq, irq, fiq, dab, pab, und, av, af, aw;
        logic [4:0] mval;
        logic [31:0] wdata, link, addr;
    } bmrf_drv_t;
    // one expected result, due at a given monitor cycle
    typedef struct {
        int cyc;
        int sel;
        logic [31:0] val;
    } bmrf_note_t;
    logic clk_i = 1'b0;
    bmrf_drv_t s; // staged next inputs
    bmrf_drv_t d; // inputs as seen by the core
    logic [31:0] rd_a_o, rd_b_o, cpsr_o, spsr_o;
    logic priv_o, ext_req_o, ext_byte_o, align_err_o, addr_exc_o;
    logic [EXT_AW-1:0] ext_addr_o;
    logic [31:0] m [16]; // supervisor view of the registers
    bmrf_note_t notes[$];
    int ncyc = 0;
    int errors = 0;
    int comparisons = 0;
    integer seed;
    logic [4:0] prev;
    logic [31:0] a;
    logic [4:0] codes [5] = '{MC_FIQ, MC_IRQ, MC_ABT, MC_UND, MC_SVC};
    logic [4:0] ecode [3] = '{MC_ABT, MC_UND, MC_ABT};

    bmrf_core u_dut (
        .clk_i(clk_i), .rstn_i(d.rstn), .ce_i(d.ce),
        .wide_program_space_bit_i(d.wp), .wide_data_space_bit_i(d.wd),
        .rd_a_idx_i(d.ra), .rd_b_idx_i(d.rb), .wr_en_i(d.we),
        .wr_idx_i(d.widx), .wr_byte_i(d.wbyte), .wr_data_i(d.wdata),
        .mode_req_i(d.mreq), .mode_val_i(d.mval), .irq_i(d.irq),
        .fiq_i(d.fiq), .dabort_i(d.dab), .pabort_i(d.pab),
        .undef_i(d.und), .exc_link_i(d.link), .acc_valid_i(d.av),
        .acc_fetch_i(d.af), .acc_word_i(d.aw), .acc_addr_i(d.addr),
        .rd_a_o(rd_a_o), .rd_b_o(rd_b_o), .cpsr_o(cpsr_o),
        .spsr_o(spsr_o), .priv_o(priv_o), .ext_addr_o(ext_addr_o),
        .ext_req_o(ext_req_o), .ext_byte_o(ext_byte_o),
        .align_err_o(align_err_o), .addr_exc_o(addr_exc_o)
    );

    // 40 MHz clock
    always #12.5 clk_i = ~clk_i;

    // compares one value and counts the outcome
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask

    // selects the watched output field
    function automatic logic [31:0] pick(input int sel);
        case (sel)
            0: pick = rd_a_o;
            1: pick = rd_b_o;
            2: pick = {27'h0, cpsr_o[4:0]};
            3: pick = {30'h0, cpsr_o[PSR_I:PSR_F]};
            4: pick = {27'h0, spsr_o[4:0]};
            5: pick = {31'h0, priv_o};
            6: pick = {28'h0, ext_req_o, ext_byte_o, align_err_o, addr_exc_o};
            default: pick = {3'h0, ext_addr_o};
        endcase
    endfunction

    // monitor: takes due notes off the queue, oldest first
    always @(negedge clk_i) begin
        ncyc = ncyc + 1;
        for (int i = 0; i < notes.size(); i++) begin
            if (notes[i].cyc == ncyc) begin
                chk(pick(notes[i].sel), notes[i].val);
                notes.delete(i);
                i--;
            end
        end
    end

    // files an expected value lat monitor cycles ahead
    task automatic note(input int sel, input int lat, input logic [31:0] v);
        notes.push_back('{ncyc + lat, sel, v});
    endtask

    // applies staged inputs and clears the one-cycle requests
    task automatic tick();
        @(posedge clk_i);
        d <= s;
        s.we = 1'b0;
        s.mreq = 1'b0;
        s.dab = 1'b0;
        s.pab = 1'b0;
        s.und = 1'b0;
        s.av = 1'b0;
    endtask

    // reset held six cycles with the given configuration
    task automatic rst(input logic wp, input logic wd);
        s.rstn = 1'b0;
        s.wp = wp;
        s.wd = wd;
        repeat (6) tick();
        s.rstn = 1'b1;
        tick();
    endtask

    // register write; model follows only when clock enable is high
    task automatic wr(input logic [3:0] i, input logic [31:0] v,
                      input logic byt);
        s.we = 1'b1;
        s.widx = i;
        s.wdata = v;
        s.wbyte = byt;
        if (s.ce) begin
            m[i] = byt ? {24'h0, v[7:0]} : v;
        end
        tick();
    endtask

    // reads both ports, answer two monitor cycles later
    task automatic rd(input logic [3:0] ia, input logic [3:0] ib,
                      input logic [31:0] ea, input logic [31:0] eb);
        s.ra = ia;
        s.rb = ib;
        tick();
        note(0, 2, ea);
        note(1, 2, eb);
    endtask

    // software mode request
    task automatic mode(input logic [4:0] c);
        s.mreq = 1'b1;
        s.mval = c;
        tick();
    endtask

    // memory access; flags are {req, byte, align, addr exception}
    task automatic acc(input logic f, input logic w, input logic [31:0] ad,
                       input logic [3:0] fl);
        s.av = 1'b1;
        s.af = f;
        s.aw = w;
        s.addr = ad;
        tick();
        note(6, 2, {28'h0, fl});
        note(7, 2, {3'h0, ad[28:0]});
    endtask

    // closing report
    task automatic end_sim();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // watchdog well beyond the roughly 90 cycles the run needs
    initial begin
        repeat (3000) @(posedge clk_i);
        errors++;
        end_sim();
    end

    // main sequence
    initial begin
        seed = 32'h0195;
        s = '0;
        s.ce = 1'b1;
        d = s;
        rst(1'b1, 1'b1);
        note(2, 3, {27'h0, MC_SVC});
        note(3, 3, 32'h3);
        note(5, 3, 32'h1);
        // fill and read back the supervisor view
        for (int k = 0; k < 15; k++) begin
            wr(4'(k), $random(seed), 1'b0);
        end
        for (int k = 0; k < 15; k++) begin
            rd(4'(k), 4'(14 - k), m[k], m[14 - k]);
        end
        wr(4'h3, $random(seed), 1'b1);
        rd(4'h3, 4'h3, m[3], m[3]);
        // a write with clock enable low must not land
        s.ce = 1'b0;
        wr(4'h1, $random(seed), 1'b0);
        s.ce = 1'b1;
        rd(4'h1, 4'h1, m[1], m[1]);
        // every privileged mode, with its banked view
        foreach (codes[k]) begin
            mode(codes[k]);
            note(2, 3, {27'h0, codes[k]});
            note(5, 3, 32'h1);
            rd(4'hD, 4'h8, (codes[k] == MC_SVC) ? m[13] : 32'h0,
               (codes[k] == MC_FIQ) ? 32'h0 : m[8]);
            rd(4'h0, 4'h7, m[0], m[7]);
        end
        mode(MC_USR);
        note(2, 3, {27'h0, MC_USR});
        note(5, 3, 32'h0);
        mode(MC_SVC);
        note(2, 3, {27'h0, MC_USR});
        // exception entries, the first from user mode, each next from the previous target
        prev = MC_USR;
        for (int k = 0; k < 3; k++) begin
            s.link = $random(seed);
            if (k == 0) begin
                s.dab = 1'b1;
            end else if (k == 1) begin
                s.und = 1'b1;
            end else begin
                s.pab = 1'b1;
            end
            tick();
            note(2, 3, {27'h0, ecode[k]});
            note(3, 3, 32'h3);
            note(4, 3, {27'h0, prev});
            rd(4'hE, 4'h0, s.link, m[0]);
            prev = ecode[k];
        end
        // interrupt levels stay masked after entry, mode must not move
        s.irq = 1'b1;
        s.fiq = 1'b1;
        tick();
        s.irq = 1'b0;
        s.fiq = 1'b0;
        note(2, 3, {27'h0, MC_ABT});
        // access checks in the wide configuration
        a = $random(seed);
        acc(1'b0, 1'b1, {a[31:2], 2'b00}, 4'h8);
        acc(1'b0, 1'b1, {a[31:2], 2'b01}, 4'h2);
        acc(1'b0, 1'b0, {a[31:1], 1'b1}, 4'hC);
        acc(1'b1, 1'b1, {a[31:2], 2'b10}, 4'h2);
        // narrow configuration
        rst(1'b0, 1'b0);
        note(2, 3, {27'h0, MC26_SVC});
        mode(MC_SVC);
        note(2, 3, {27'h0, MC26_SVC});
        mode(MC26_USR);
        note(2, 3, {27'h0, MC26_USR});
        note(5, 3, 32'h0);
        s.dab = 1'b1;
        tick();
        note(2, 3, {27'h0, MC26_SVC});
        acc(1'b1, 1'b1, 32'h0800_0000, 4'h1);
        acc(1'b0, 1'b1, 32'h0400_0004, 4'h1);
        note(2, 3, {27'h0, MC26_SVC});
        // narrow program space with wide data space
        s.wd = 1'b1;
        acc(1'b0, 1'b1, 32'hFC00_0000, 4'h8);
        acc(1'b1, 1'b1, 32'hFC00_0000, 4'h1);
        repeat (5) tick();
        if (notes.size() != 0) begin
            errors++;
        end
        end_sim();
    end
endmodule
`default_nettype wire
